// File: design/fbm_host.sv
// Host-side bus controller that drives an asynchronous parallel flash by its pins.
// Assumes one request at a time on the command port and a flash wired in word mode.
// Overview of operation
// - Command writes pulse write strobe low with select low and gate high.
// - A buffered programming run carries at most 16 words.
// - Accelerated programming uses the two-cycle program sequence.
// - Elevated voltage stands only during an accelerated program.
// - Host flags, through the restart bit of the response, a buffered run that a reset aborted; the user restarts it.
// - Reads drive select and gate low with write strobe high.
`timescale 1ns/1ns
module fbm_host
    import fbm_pkg::*;
#(
    parameter int BUF_WORDS = fbm_pkg::BUF_MAX_WORDS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire fbm_pkg::fbm_req_s cmdReq,
    input wire logic cmdValid,
    output logic cmdReady,
    output fbm_pkg::fbm_rsp_s cmdRsp,
    output fbm_pkg::fbm_pins_s flashPins,
    input wire logic [fbm_pkg::DATA_W-1:0] flashDataIn
);
    import fbm_pkg::*;

    if (BUF_WORDS < 1 || BUF_WORDS > BUF_MAX_WORDS)
    begin : g_bad_buf
        $error("BUF_WORDS out of range");
    end
    if (CYC_RP >= (1 << CNT_W) || CYC_FULL + SYNC_STAGES >= (1 << CNT_W))
    begin : g_bad_cnt
        $error("Timing count too wide for counter");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_ACC_RISE,
        ST_RST_LOW,
        ST_RST_RECOVER
    } fbm_state_e;

    typedef struct packed {
        fbm_state_e state;
        logic [CNT_W-1:0] cnt;
        fbm_pins_s pins;
        fbm_rsp_s rsp;
        logic ready;
        logic [DATA_W-1:0] hold;
        logic secondCycle;
        logic [BUF_CNT_W-1:0] bufCnt;
        logic pageOpen;
        logic [ADDR_W-1:PAGE_LSB] pageTag;
        logic restartDue;
    } fbm_ctl_s;

    localparam fbm_pins_s PINS_RST = '{ceB: 1'b1, oeB: 1'b1, weB: 1'b1, resetB: 1'b1,
        accHigh: 1'b0, addr: '0, dataOut: '0, dataOe: 1'b0};
    localparam logic [BUF_CNT_W-1:0] BUF_LIMIT = BUF_CNT_W'(BUF_WORDS);

    fbm_ctl_s ctl_reg;
    fbm_ctl_s ctl_next;
    logic [DATA_W-1:0] dataSync;
    logic [ADDR_W-1:0] effAddr;
    logic samePage;

    fbm_sync #(.WIDTH(DATA_W)) u_data_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn(flashDataIn),
        .syncOut(dataSync)
    );

    // Sector mode takes a sector number and places it at the sector base
    assign effAddr = cmdReq.sectorMode ?
        {cmdReq.addr[SECT_W-1:0], {SECT_LSB{1'b0}}} : cmdReq.addr;
    assign samePage = ctl_reg.pageOpen && (effAddr[ADDR_W-1:PAGE_LSB] == ctl_reg.pageTag);

    always_comb
    begin
        ctl_next = ctl_reg;
        ctl_next.rsp.valid = 1'b0;
        ctl_next.rsp.refused = 1'b0;
        ctl_next.rsp.restart = 1'b0;
        unique case (ctl_reg.state)
            ST_IDLE:
            begin
                if (cmdValid && ctl_reg.ready)
                begin
                    unique case (cmdReq.op)
                        FBM_OP_READ:
                        begin
                            // Select and gate low, strobe high
                            ctl_next.pins.addr = effAddr;
                            ctl_next.pins.ceB = 1'b0;
                            ctl_next.pins.oeB = 1'b0;
                            ctl_next.pins.weB = 1'b1;
                            ctl_next.pins.dataOe = 1'b0;
                            ctl_next.ready = 1'b0;
                            ctl_next.state = ST_RD_WAIT;
                            // Page hits wait less, else full select time
                            ctl_next.cnt = samePage ? CNT_W'(CYC_PAGE + SYNC_STAGES - 1) :
                                CNT_W'(CYC_FULL + SYNC_STAGES - 1);
                        end
                        FBM_OP_WRITE:
                        begin
                            if (cmdReq.bufWord && ctl_reg.bufCnt == BUF_LIMIT)
                            begin
                                // Refuse a word beyond the buffer size
                                ctl_next.rsp.valid = 1'b1;
                                ctl_next.rsp.refused = 1'b1;
                            end
                            else
                            begin
                                ctl_next.bufCnt = cmdReq.bufWord ? ctl_reg.bufCnt + 1'b1 : '0;
                                ctl_next.pins.addr = effAddr;
                                ctl_next.pins.dataOut = cmdReq.data;
                                // Gate high no later than the cycle in which the strobe falls
                                ctl_next.pins.oeB = 1'b1;
                                ctl_next.pins.ceB = 1'b0;
                                ctl_next.pins.weB = 1'b0;
                                ctl_next.pins.dataOe = 1'b1;
                                ctl_next.pageOpen = 1'b0;
                                ctl_next.secondCycle = 1'b1;
                                ctl_next.cnt = CNT_W'(CYC_WP - 1);
                                ctl_next.ready = 1'b0;
                                ctl_next.state = ST_WR_LOW;
                            end
                        end
                        FBM_OP_ACC_PROG:
                        begin
                            // Raise the voltage only for this program
                            ctl_next.pins.accHigh = 1'b1;
                            ctl_next.pins.ceB = 1'b1;
                            ctl_next.pins.oeB = 1'b1;
                            ctl_next.pins.addr = effAddr;
                            ctl_next.pins.dataOut = cmdReq.code;
                            ctl_next.hold = cmdReq.data;
                            ctl_next.secondCycle = 1'b0;
                            ctl_next.pageOpen = 1'b0;
                            ctl_next.bufCnt = '0;
                            ctl_next.cnt = CNT_W'(CYC_ACCSU - 1);
                            ctl_next.ready = 1'b0;
                            ctl_next.state = ST_ACC_RISE;
                        end
                        FBM_OP_RESET:
                        begin
                            // Pulse at least the minimum width
                            ctl_next.pins = PINS_RST;
                            ctl_next.pins.resetB = 1'b0;
                            ctl_next.pins.addr = ctl_reg.pins.addr;
                            ctl_next.pageOpen = 1'b0;
                            ctl_next.restartDue = (ctl_reg.bufCnt != '0);
                            ctl_next.cnt = CNT_W'(CYC_RP - 1);
                            ctl_next.ready = 1'b0;
                            ctl_next.state = ST_RST_LOW;
                        end
                    endcase
                end
                else
                begin
                    // No back-to-back read: drop to standby
                    ctl_next.pins.ceB = 1'b1;
                    ctl_next.pins.oeB = 1'b1;
                    ctl_next.pageOpen = 1'b0;
                    ctl_next.ready = 1'b1;
                end
            end
            ST_RD_WAIT:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    ctl_next.rsp.valid = 1'b1;
                    ctl_next.rsp.data = dataSync;
                    ctl_next.pageOpen = 1'b1;
                    ctl_next.pageTag = ctl_reg.pins.addr[ADDR_W-1:PAGE_LSB];
                    ctl_next.ready = 1'b1;
                    ctl_next.state = ST_IDLE;
                end
            end
            ST_ACC_RISE:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    // First of the two bypass program cycles
                    ctl_next.pins.ceB = 1'b0;
                    ctl_next.pins.weB = 1'b0;
                    ctl_next.pins.dataOe = 1'b1;
                    ctl_next.cnt = CNT_W'(CYC_WP - 1);
                    ctl_next.state = ST_WR_LOW;
                end
            end
            ST_WR_LOW:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    ctl_next.pins.weB = 1'b1;
                    ctl_next.cnt = CNT_W'(CYC_WPH - 1);
                    ctl_next.state = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    if (!ctl_reg.secondCycle)
                    begin
                        // Program data cycle
                        ctl_next.pins.dataOut = ctl_reg.hold;
                        ctl_next.pins.weB = 1'b0;
                        ctl_next.secondCycle = 1'b1;
                        ctl_next.cnt = CNT_W'(CYC_WP - 1);
                        ctl_next.state = ST_WR_LOW;
                    end
                    else
                    begin
                        // Voltage falls as soon as the sequence ends
                        ctl_next.pins.accHigh = 1'b0;
                        ctl_next.pins.ceB = 1'b1;
                        ctl_next.pins.dataOe = 1'b0;
                        ctl_next.rsp.valid = 1'b1;
                        ctl_next.ready = 1'b1;
                        ctl_next.state = ST_IDLE;
                    end
                end
            end
            ST_RST_LOW:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    ctl_next.pins.resetB = 1'b1;
                    ctl_next.cnt = CNT_W'(CYC_RH - 1);
                    ctl_next.state = ST_RST_RECOVER;
                end
            end
            ST_RST_RECOVER:
            begin
                ctl_next.cnt = ctl_reg.cnt - 1'b1;
                if (ctl_reg.cnt == '0)
                begin
                    // Tell the user the aborted run must be restarted
                    ctl_next.rsp.valid = 1'b1;
                    ctl_next.rsp.restart = ctl_reg.restartDue;
                    ctl_next.restartDue = 1'b0;
                    ctl_next.bufCnt = '0;
                    ctl_next.ready = 1'b1;
                    ctl_next.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_reg <= '{state: ST_IDLE, cnt: '0, pins: PINS_RST, rsp: '0, ready: 1'b0,
                hold: '0, secondCycle: 1'b0, bufCnt: '0, pageOpen: 1'b0, pageTag: '0,
                restartDue: 1'b0};
        end
        else
        begin
            ctl_reg <= ctl_next;
        end
    end

    assign cmdReady = ctl_reg.ready;
    assign cmdRsp = ctl_reg.rsp;
    assign flashPins = ctl_reg.pins;

    // Helper counters watched only by assertions
    logic [CNT_W-1:0] rstLowCnt;
    logic [CNT_W-1:0] oeLowCnt;
    logic [1:0] accStrobes;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstLowCnt <= '0;
            oeLowCnt <= '0;
            accStrobes <= '0;
        end
        else
        begin
            rstLowCnt <= ctl_reg.pins.resetB ? '0 : rstLowCnt + 1'b1;
            oeLowCnt <= ctl_reg.pins.oeB ? '0 : oeLowCnt + 1'b1;
            if (!ctl_reg.pins.accHigh)
                accStrobes <= '0;
            else if (ctl_reg.pins.weB && !ctl_next.pins.weB)
                accStrobes <= accStrobes + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_write_levels;
        !flashPins.weB |-> !flashPins.ceB && flashPins.oeB && flashPins.dataOe;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("Bad write levels");

    property p_read_levels;
        !flashPins.oeB |-> !flashPins.ceB && flashPins.weB && !flashPins.dataOe;
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("Bad read levels");

    property p_no_drive_gate;
        flashPins.dataOe |-> flashPins.oeB;
    endproperty
    a_no_drive_gate: assert property (p_no_drive_gate) else $error("Drive with gate low");

    property p_buf_limit;
        ctl_reg.bufCnt <= BUF_LIMIT;
    endproperty
    a_buf_limit: assert property (p_buf_limit) else $error("Buffer count over limit");

    property p_reset_width;
        $rose(flashPins.resetB) |-> $past(rstLowCnt) >= CNT_W'(CYC_RP - 1);
    endproperty
    a_reset_width: assert property (p_reset_width) else $error("Reset pulse too short");

    property p_read_wait;
        cmdRsp.valid && $past(ctl_reg.state) == ST_RD_WAIT && !$past(ctl_reg.pageOpen, 2)
            |-> oeLowCnt >= CNT_W'(CYC_FULL + SYNC_STAGES);
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("Read sampled too early");

    property p_acc_two;
        accStrobes <= 2'd2;
    endproperty
    a_acc_two: assert property (p_acc_two) else $error("Too many accelerated strobes");

    sequence s_acc_end;
        ctl_reg.state == ST_WR_HIGH && ctl_reg.secondCycle && ctl_reg.cnt == '0;
    endsequence
    property p_acc_drop;
        flashPins.accHigh and s_acc_end |=> !flashPins.accHigh ##1 !flashPins.accHigh;
    endproperty
    a_acc_drop: assert property (p_acc_drop) else $error("Voltage held after program");

    property p_acc_only_prog;
        flashPins.accHigh |-> flashPins.resetB && flashPins.oeB;
    endproperty
    a_acc_only_prog: assert property (p_acc_only_prog) else $error("Voltage during other op");
endmodule

// File: design/fbm_pkg.sv
// Constants and carrier types for the flash bus mode controller.
// Assumes a 16-bit word-mode flash with 21 word-address pins and a 20 MHz system clock.
package fbm_pkg;

    localparam int T_CLK_NS = 50;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int LOW_BYTE_W = 8;
    // Sector field: low six bits of the address field pick a 32 Kword sector
    localparam int SECT_LSB = 15;
    localparam int SECT_W = 6;
    localparam int PAGE_LSB = 2;
    localparam int BUF_MAX_WORDS = 16;
    localparam int BUF_CNT_W = 5;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 8;

    // Times in ns; plain defaults where no figure is given
    localparam int ADDR_ACCESS_NS = 100;
    localparam int SELECT_ACCESS_NS = 100;
    localparam int PAGE_ACCESS_NS = 30;
    localparam int WE_PULSE_NS = 60;
    localparam int WE_HIGH_NS = 60;
    localparam int MIN_RESET_PULSE_NS = 500;
    localparam int RESET_READY_NS = 200;
    localparam int ACC_SETUP_NS = 250;

    // Least times round up to whole cycles
    localparam int CYC_FULL = ((ADDR_ACCESS_NS > SELECT_ACCESS_NS ? ADDR_ACCESS_NS :
        SELECT_ACCESS_NS) + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_PAGE = (PAGE_ACCESS_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_WP = (WE_PULSE_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_WPH = (WE_HIGH_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_RP = (MIN_RESET_PULSE_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_RH = (RESET_READY_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int CYC_ACCSU = (ACC_SETUP_NS + T_CLK_NS - 1) / T_CLK_NS;

    typedef enum logic [1:0] {
        FBM_OP_READ,
        FBM_OP_WRITE,
        FBM_OP_ACC_PROG,
        FBM_OP_RESET
    } fbm_op_e;

    typedef struct packed {
        fbm_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] code;
        logic bufWord;
        logic sectorMode;
    } fbm_req_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
        logic refused;
        logic restart;
    } fbm_rsp_s;

    typedef struct packed {
        logic ceB;
        logic oeB;
        logic weB;
        logic resetB;
        logic accHigh;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
    } fbm_pins_s;

endpackage

// File: design/fbm_sync.sv
// Two-flop synchroniser for the flash data bus.
// Assumes the input is asynchronous to clk_sys and only the last stage is read.
`timescale 1ns/1ns
module fbm_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } fbm_sync_s;

    fbm_sync_s sync_reg;
    fbm_sync_s sync_next;

    always_comb
    begin
        sync_next.meta = asyncIn;
        sync_next.stable = sync_reg.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign syncOut = sync_reg.stable;
endmodule

// File: test/fbm_flash_model.sv
// Behavioural asynchronous flash in word mode, seen only from its pins.
// Assumes one controller drives every pin; command decoding and status are left out.
`timescale 1ns/1ns
module fbm_flash_model
    import fbm_pkg::*;
(
    input wire fbm_pkg::fbm_pins_s flashPins,
    output logic [fbm_pkg::DATA_W-1:0] flashDataIn,
    output int faults
);
    import fbm_pkg::*;
    // Margin keeps fresh data off the controller's sampling edge
    localparam int MARGIN_NS = 1;
    logic [DATA_W-1:0] mem [int];
    logic codeSeen;
    logic dataReady;
    logic pageOpen;
    logic [ADDR_W-1:PAGE_LSB] openPage;
    realtime resetFell;

    function automatic logic [DATA_W-1:0] arrayWord(input logic [ADDR_W-1:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : (a[15:0] ^ 16'hC3C3);
    endfunction

    initial
    begin
        faults = 0;
        codeSeen = 1'b0;
        dataReady = 1'b0;
        pageOpen = 1'b0;
        resetFell = 0.0;
    end

    // A new address or select restarts the access; page hits are faster
    always @(flashPins.addr or flashPins.ceB)
    begin
        if (pageOpen && !flashPins.ceB && flashPins.addr[ADDR_W-1:PAGE_LSB] == openPage)
            dataReady <= #(PAGE_ACCESS_NS - MARGIN_NS) 1'b1;
        else
            dataReady <= #(SELECT_ACCESS_NS - MARGIN_NS) 1'b1;
        dataReady = 1'b0;
        pageOpen = !flashPins.ceB;
        openPage = flashPins.addr[ADDR_W-1:PAGE_LSB];
    end

    // Released bus shows the inverse so a stale sample cannot pass
    always @*
    begin
        if (flashPins.resetB && !flashPins.ceB && !flashPins.oeB && dataReady)
            flashDataIn = arrayWord(flashPins.addr);
        else
            flashDataIn = ~arrayWord(flashPins.addr);
    end

    // Writes land at once, so a later deselect cannot abort them
    always @(posedge flashPins.weB)
    begin
        if (!flashPins.ceB && flashPins.resetB)
        begin
            if (!flashPins.oeB)
                faults++;
            if (flashPins.accHigh && !codeSeen)
                codeSeen = 1'b1;
            else
            begin
                mem[int'(flashPins.addr)] = flashPins.dataOut;
                codeSeen = 1'b0;
            end
        end
    end

    always @(negedge flashPins.oeB)
        if (flashPins.accHigh || !flashPins.weB)
            faults++;

    always @(negedge flashPins.resetB)
    begin
        resetFell = $realtime;
        codeSeen = 1'b0;
    end

    always @(posedge flashPins.resetB)
        if (resetFell > 0.0 && $realtime - resetFell < MIN_RESET_PULSE_NS)
            faults++;

    always @(negedge flashPins.accHigh)
        codeSeen = 1'b0;
endmodule

// File: test/flash_bus_mode_control_tb.sv
// Self-checking bench for the flash host controller against a behavioural flash.
// Assumes the flash model sees the controller's pins only.
`timescale 1ns/1ns
module flash_bus_mode_control_tb;
    import fbm_pkg::*;
    localparam logic [15:0] FILL = 16'hC3C3;
    logic clk_sys;
    logic rst_b;
    logic cmdValid;
    logic cmdReady;
    fbm_req_s cmdReq;
    fbm_rsp_s cmdRsp;
    fbm_pins_s flashPins;
    logic [DATA_W-1:0] flashDataIn;
    int faults;
    int err_count;
    int compares;

    fbm_host u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cmdReq(cmdReq), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdRsp(cmdRsp), .flashPins(flashPins), .flashDataIn(flashDataIn));
    fbm_flash_model u_flash (.flashPins(flashPins), .flashDataIn(flashDataIn), .faults(faults));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        compares++;
        if (got != exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    function automatic fbm_req_s mk(input fbm_op_e op, input logic [ADDR_W-1:0] a,
        input logic [15:0] d, input logic [15:0] c, input logic bw, input logic sm);
        return '{op: op, addr: a, data: d, code: c, bufWord: bw, sectorMode: sm};
    endfunction

    // Ready is read before the edge's updates land, as the controller saw it
    task automatic wait_take();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (cmdReady !== 1'b1 && n < 40);
        chk_cnt(n < 40, 1, "request taken");
        if (n >= 40)
            print_verdict();
    endtask

    task automatic wait_rsp(input int lat, output fbm_rsp_s r);
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (cmdRsp.valid !== 1'b1 && k < 40);
        r = cmdRsp;
        chk_cnt(k - 1, lat, "answer cycles");
        if (k >= 40)
            print_verdict();
    endtask

    task automatic req(input fbm_req_s q, input int lat, output fbm_rsp_s r);
        cmdReq <= q;
        cmdValid <= 1'b1;
        wait_take();
        cmdValid <= 1'b0;
        wait_rsp(lat, r);
    endtask

    task automatic wr_rd(input logic [ADDR_W-1:0] wa, input logic sm,
        input logic [ADDR_W-1:0] ra, input logic [15:0] d);
        fbm_rsp_s r;
        req(mk(FBM_OP_WRITE, wa, d, 16'h0000, 1'b0, sm), 4, r);
        req(mk(FBM_OP_READ, ra, 16'h0000, 16'h0000, 1'b0, 1'b0), 4, r);
        chk_val(r.data, d, "read back");
    endtask

    task automatic t_read();
        fbm_rsp_s r;
        req(mk(FBM_OP_READ, 21'h01_2345, 16'h0000, 16'h0000, 1'b0, 1'b0), 4, r);
        chk_val(r.data, 16'h2345 ^ FILL, "array read");
        wr_rd(21'h00_2000, 1'b0, 21'h00_2000, 16'hBEEF);
        $display("test read and write done");
    endtask

    task automatic t_page();
        fbm_rsp_s r;
        cmdReq <= mk(FBM_OP_READ, 21'h00_0100, 16'h0000, 16'h0000, 1'b0, 1'b0);
        cmdValid <= 1'b1;
        wait_take();
        // Valid stays up so the second read is taken in the answer cycle
        cmdReq <= mk(FBM_OP_READ, 21'h00_0103, 16'h0000, 16'h0000, 1'b0, 1'b0);
        wait_rsp(4, r);
        chk_val(r.data, 16'h0100 ^ FILL, "page first word");
        cmdValid <= 1'b0;
        wait_rsp(3, r);
        chk_val(r.data, 16'h0103 ^ FILL, "page hit word");
        $display("test page done");
    endtask

    task automatic t_sector();
        wr_rd(21'h00_0005, 1'b1, 21'h02_8000, 16'h5A5A);
        wr_rd(21'h00_003F, 1'b1, 21'h1F_8000, 16'hA5A5);
        $display("test sector done");
    endtask

    task automatic t_acc();
        fbm_rsp_s r;
        req(mk(FBM_OP_ACC_PROG, 21'h00_3000, 16'h1357, 16'h00A0, 1'b0, 1'b0), 13, r);
        chk_val(16'(flashPins.accHigh), 16'h0000, "voltage dropped");
        wr_rd(21'h00_3001, 1'b0, 21'h00_3001, 16'h2468);
        req(mk(FBM_OP_READ, 21'h00_3000, 16'h0000, 16'h0000, 1'b0, 1'b0), 4, r);
        chk_val(r.data, 16'h1357, "accelerated word");
        $display("test accelerated done");
    endtask

    task automatic t_buffer();
        fbm_rsp_s r;
        for (int i = 0; i < BUF_MAX_WORDS; i++)
        begin
            req(mk(FBM_OP_WRITE, 21'h00_4000 + 21'(i), 16'(i), 16'h0000, 1'b1, 1'b0), 4, r);
            chk_val(16'(r.refused), 16'h0000, "buffered word taken");
        end
        req(mk(FBM_OP_WRITE, 21'h00_4010, 16'hFFFF, 16'h0000, 1'b1, 1'b0), 0, r);
        chk_val(16'(r.refused), 16'h0001, "extra word refused");
        req(mk(FBM_OP_READ, 21'h00_4010, 16'h0000, 16'h0000, 1'b0, 1'b0), 4, r);
        chk_val(r.data, 16'h4010 ^ FILL, "refused word absent");
        $display("test buffer done");
    endtask

    task automatic t_reset();
        fbm_rsp_s r;
        // Plain write closes the full run left by the buffer test
        req(mk(FBM_OP_WRITE, 21'h00_5001, 16'h1111, 16'h0000, 1'b0, 1'b0), 4, r);
        req(mk(FBM_OP_WRITE, 21'h00_5000, 16'h7777, 16'h0000, 1'b1, 1'b0), 4, r);
        req(mk(FBM_OP_RESET, 21'h00_0000, 16'h0000, 16'h0000, 1'b0, 1'b0), 14, r);
        chk_val(16'(r.restart), 16'h0001, "aborted run flagged");
        req(mk(FBM_OP_RESET, 21'h00_0000, 16'h0000, 16'h0000, 1'b0, 1'b0), 14, r);
        chk_val(16'(r.restart), 16'h0000, "no run to restart");
        req(mk(FBM_OP_READ, 21'h00_2000, 16'h0000, 16'h0000, 1'b0, 1'b0), 4, r);
        chk_val(r.data, 16'hBEEF, "array read after reset");
        $display("test reset done");
    endtask

    initial
    begin
        rst_b = 1'b0;
        cmdValid = 1'b0;
        cmdReq = '0;
        err_count = 0;
        compares = 0;
        repeat (3) @(posedge clk_sys);
        chk_val(16'({flashPins.ceB, flashPins.oeB, flashPins.weB, flashPins.resetB,
            flashPins.accHigh, flashPins.dataOe}), 16'h003C, "pins in reset");
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_read();
        t_page();
        t_sector();
        t_acc();
        t_buffer();
        t_reset();
        chk_cnt(faults, 0, "bus faults seen by flash");
        print_verdict();
    end
endmodule
